//--- inc/pfb_regs.svh
// Register offsets, field positions, commands and timing counts of the flash host.
`ifndef PFB_REGS_SVH
`define PFB_REGS_SVH

// ----------------------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------------------
`define PFB_REG_CTRL     3'h0
`define PFB_REG_ADDR     3'h1
`define PFB_REG_DATA     3'h2
`define PFB_REG_STAT     3'h3
`define PFB_REG_COUNT    3'h4
`define PFB_REG_RDATA    3'h5

// ----------------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------------
`define PFB_CTRL_START   0
`define PFB_CTRL_OP_LO   1
`define PFB_CTRL_OP_HI   3
`define PFB_CTRL_BYTE    4
`define PFB_CTRL_PROT    5
`define PFB_CTRL_ACCEL   6
`define PFB_STAT_BUSY    0
`define PFB_STAT_READY   1
`define PFB_STAT_NEED    2
`define PFB_STAT_ERR     3
`define PFB_STAT_TMO     4

// ----------------------------------------------------------------------------
// Command cycles
// ----------------------------------------------------------------------------
`define PFB_UNLOCK1_A    27'h0000555
`define PFB_UNLOCK2_A    27'h00002aa
`define PFB_UNLOCK1_D    16'h00aa
`define PFB_UNLOCK2_D    16'h0055
`define PFB_CMD_PROG     16'h00a0
`define PFB_CMD_BUF_LOAD 16'h0025
`define PFB_CMD_CONFIRM  16'h0029
`define PFB_CMD_RESET    16'h00f0

// ----------------------------------------------------------------------------
// Timing in nanoseconds and derived clock counts
// ----------------------------------------------------------------------------
`define PFB_CLK_NS       100
`define PFB_T_ACCESS_NS  100
`define PFB_T_WP_NS      50
`define PFB_T_RP_NS      500
`define PFB_T_READY_NS   10000
`define PFB_SYNC_CYC     16'h0003
`define PFB_ACCESS_CYC   16'((`PFB_T_ACCESS_NS + `PFB_CLK_NS - 1) / `PFB_CLK_NS)
`define PFB_WP_CYC       16'((`PFB_T_WP_NS + `PFB_CLK_NS - 1) / `PFB_CLK_NS)
`define PFB_RP_CYC       16'((`PFB_T_RP_NS + `PFB_CLK_NS - 1) / `PFB_CLK_NS)
`define PFB_READY_CYC    16'(`PFB_T_READY_NS / `PFB_CLK_NS)

`endif

//--- inc/pfb_pkg.sv
// Types shared by the flash host files.
package pfb_pkg;

	// Operations that software can start.
	typedef enum logic [2:0]
	{
		OP_READ      = 3'h0,
		OP_PROG      = 3'h1,
		OP_BUF       = 3'h2,
		OP_ABORT_RST = 3'h3,
		OP_READ_RST  = 3'h4,
		OP_HW_RST    = 3'h5
	} pfb_op_t;

	// Pin sequencer states.
	typedef enum logic [2:0]
	{
		ST_IDLE     = 3'h0,
		ST_STEP     = 3'h1,
		ST_SETUP    = 3'h2,
		ST_PULSE    = 3'h3,
		ST_HOLD     = 3'h4,
		ST_READ     = 3'h5,
		ST_RST_LOW  = 3'h6,
		ST_RST_WAIT = 3'h7
	} pfb_state_t;

endpackage : pfb_pkg

//--- core/pfb_sync3.sv
// Three-stage input synchroniser that accepts a bit once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none

module pfb_sync3 #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic             enable_in,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] value_out
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed
	{
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] val;
	} pfb_sync_t;

	pfb_sync_t st;
	pfb_sync_t next_st;

	// Shift the stages and take each bit whose later stages agree.
	always_comb
	begin
		next_st = st;
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.val = (st.s2 & ~(st.s2 ^ st.s3)) | (st.val & (st.s2 ^ st.s3));
	end

	// Register the state; reset clears every stage.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			st <= '0;
		else if (enable_in)
			st <= next_st;
	end

	assign value_out = st.val;

endmodule : pfb_sync3

`default_nettype wire

//--- core/pfb_host.sv
// Host controller that drives a parallel flash over its pins from Avalon registers.
//
// Overview of operation
// - Read by lowering chip select and output enable with write strobe high.
// - Each write: chip select low, output enable high, then pulse write low.
// - Issue only the fixed command codes, never a software-made opcode; unlisted ops 6 and 7 write DATA to ADDR as one plain cycle.
// - Buffer program: two unlocks, load, count minus one, pairs, confirm; the code skips the two unlocks when the ACCEL control bit is set.
// - After an abort, software sends the abort reset sequence before more.
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pfb_regs.svh"

module pfb_host #(
	parameter logic [15:0] ACCESS_CYC = `PFB_ACCESS_CYC,
	parameter logic [15:0] WP_CYC     = `PFB_WP_CYC,
	parameter logic [15:0] RP_CYC     = `PFB_RP_CYC,
	parameter logic [15:0] READY_CYC  = `PFB_READY_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        ce_in,
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	output logic      [25:0] flash_addr_out,
	output logic      [15:0] flash_data_out,
	output logic      [15:0] flash_data_oe_out,
	input  wire logic [15:0] flash_data_in,
	output logic             flash_ce_n_out,
	output logic             flash_we_n_out,
	output logic             flash_oe_n_out,
	output logic             flash_reset_n_out,
	output logic             flash_byte_n_out,
	output logic             protect_accel_n_out,
	output logic             accel_request_out,
	input  wire logic        ready_busy_in
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed
	{
		pfb_pkg::pfb_state_t fsm;
		pfb_pkg::pfb_op_t    op;
		logic [9:0]          step;
		logic [15:0]         cnt;
		logic [26:0]         addr;
		logic [15:0]         wdata;
		logic [7:0]          count;
		logic                byte_mode;
		logic                prot_low;
		logic                accel;
		logic                full;
		logic                last;
		logic [15:0]         rdata;
		logic                err;
		logic                tmo;
		logic                wreq;
		logic [31:0]         rdbus;
		logic [25:0]         pa;
		logic [15:0]         pd;
		logic [15:0]         pd_oe;
		logic                ce_n;
		logic                we_n;
		logic                oe_n;
		logic                rst_n;
		logic                byte_n;
		logic                prot_n;
	} pfb_host_t;

	pfb_host_t   st;
	pfb_host_t   next_st;
	logic [15:0] data_sync;
	logic        ready_sync;

	// Merge a write into a register under the byte enables.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		return r;
	endfunction : merge

	// Turn a word-mode command address into an item address for the mode.
	function automatic logic [26:0] cmd_addr(input logic [26:0] a,
		input logic bm);
		return bm ? {a[25:0], 1'b0} : a;
	endfunction : cmd_addr

	// ------------------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------------------
	pfb_sync3 #(.WIDTH(16)) u_sync_data (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.enable_in (ce_in),
		.pin_in    (flash_data_in),
		.value_out (data_sync)
	);

	pfb_sync3 #(.WIDTH(1)) u_sync_ready (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.enable_in (ce_in),
		.pin_in    (ready_busy_in),
		.value_out (ready_sync)
	);

	// ------------------------------------------------------------------------
	// Next state: register bus, command steps and pin sequencing
	// ------------------------------------------------------------------------
	always_comb
	begin
		logic [26:0] it_a;
		logic [15:0] it_d;
		logic        it_last;
		logic        it_load;
		logic        need;
		logic        req;
		logic        stall;
		logic [9:0]  lidx;
		logic [31:0] w;
		it_a = st.addr;
		it_d = st.wdata;
		it_last = 1'b0;
		it_load = 1'b0;
		w = 32'h00000000;
		need = 1'b0;
		req = 1'b0;
		stall = 1'b0;
		lidx = st.step - 10'h004;
		next_st = st;
		next_st.wreq = 1'b1;

		// Command item for the current step of the running operation.
		unique case (st.op)
			pfb_pkg::OP_PROG, pfb_pkg::OP_BUF, pfb_pkg::OP_ABORT_RST:
			begin
				if (st.step == 10'h000)
				begin
					it_a = cmd_addr(`PFB_UNLOCK1_A, st.byte_mode);
					it_d = `PFB_UNLOCK1_D;
				end
				else if (st.step == 10'h001)
				begin
					it_a = cmd_addr(`PFB_UNLOCK2_A, st.byte_mode);
					it_d = `PFB_UNLOCK2_D;
				end
				else if (st.op == pfb_pkg::OP_ABORT_RST)
				begin
					it_a = cmd_addr(`PFB_UNLOCK1_A, st.byte_mode);
					it_d = `PFB_CMD_RESET;
					it_last = 1'b1;
				end
				else if (st.op == pfb_pkg::OP_PROG)
				begin
					if (st.step == 10'h002)
					begin
						it_a = cmd_addr(`PFB_UNLOCK1_A, st.byte_mode);
						it_d = `PFB_CMD_PROG;
					end
					else
						it_last = 1'b1;
				end
				else if (st.step == 10'h002)
					it_d = `PFB_CMD_BUF_LOAD;
				else if (st.step == 10'h003)
					it_d = {8'h00, st.count};
				else if (lidx <= {2'b00, st.count})
				begin
					// Loads walk upward from the start inside one page.
					it_a = st.addr + {17'h00000, lidx};
					it_load = 1'b1;
				end
				else
				begin
					it_d = `PFB_CMD_CONFIRM;
					it_last = 1'b1;
				end
			end
			pfb_pkg::OP_READ_RST:
			begin
				it_d = `PFB_CMD_RESET;
				it_last = 1'b1;
			end
			default:
				it_last = 1'b1;
		endcase

		need = (st.fsm == pfb_pkg::ST_STEP) && it_load && !st.full;
		req = avs_read_in || avs_write_in;
		stall = avs_write_in && st.full &&
			(avs_address_in[4:2] == `PFB_REG_DATA);

		// Bus slave: first cycle answers, second cycle takes effect.
		if (req && st.wreq && !stall)
		begin
			next_st.wreq = 1'b0;
			unique case (avs_address_in[4:2])
				`PFB_REG_CTRL:
					next_st.rdbus = {25'h0, st.accel, st.prot_low,
						st.byte_mode, st.op, 1'b0};
				`PFB_REG_ADDR:
					next_st.rdbus = {5'h00, st.addr};
				`PFB_REG_DATA:
					next_st.rdbus = {16'h0000, st.wdata};
				`PFB_REG_STAT:
					next_st.rdbus = {27'h0, st.tmo, st.err, need,
						ready_sync, st.fsm != pfb_pkg::ST_IDLE};
				`PFB_REG_COUNT:
					next_st.rdbus = {24'h000000, st.count};
				`PFB_REG_RDATA:
					next_st.rdbus = {16'h0000, st.rdata};
				default:
					next_st.rdbus = 32'h00000000;
			endcase
		end

		// Register writes that take effect on the accepting edge.
		if (avs_write_in && !st.wreq)
		begin
			unique case (avs_address_in[4:2])
				`PFB_REG_CTRL:
				begin
					w = merge({25'h0, st.accel, st.prot_low, st.byte_mode,
						st.op, 1'b0}, avs_writedata_in, avs_byteenable_in);
					if (st.fsm == pfb_pkg::ST_IDLE)
					begin
						next_st.accel = w[`PFB_CTRL_ACCEL];
						next_st.prot_low = w[`PFB_CTRL_PROT];
						next_st.byte_mode = w[`PFB_CTRL_BYTE];
						next_st.byte_n = !w[`PFB_CTRL_BYTE];
						next_st.prot_n = !w[`PFB_CTRL_PROT];
						// The lowest address pin is driven from the mode change on.
						next_st.pd_oe = w[`PFB_CTRL_BYTE] ? 16'h8000
							: 16'h0000;
						next_st.op = pfb_pkg::pfb_op_t'(
							w[`PFB_CTRL_OP_HI:`PFB_CTRL_OP_LO]);
						if (w[`PFB_CTRL_START])
						begin
							next_st.err = 1'b0;
							next_st.tmo = 1'b0;
							next_st.full = 1'b0;
							next_st.step = (w[`PFB_CTRL_ACCEL] &&
								w[`PFB_CTRL_OP_HI:`PFB_CTRL_OP_LO] != 3'h3)
								? 10'h002 : 10'h000;
							next_st.fsm = pfb_pkg::ST_STEP;
							if (w[`PFB_CTRL_OP_HI:`PFB_CTRL_OP_LO] == 3'h5)
								next_st.fsm = pfb_pkg::ST_RST_LOW;
							if (w[`PFB_CTRL_OP_HI:`PFB_CTRL_OP_LO] == 3'h2 &&
								(w[`PFB_CTRL_BYTE]
								? ({1'b0, st.addr[8:0]} + {2'b00, st.count})
								: ({2'b00, st.addr[7:0]} + {2'b00, st.count}))
								> (w[`PFB_CTRL_BYTE] ? 10'h1ff : 10'h0ff))
							begin
								next_st.err = 1'b1;
								next_st.fsm = pfb_pkg::ST_IDLE;
							end
							next_st.cnt = RP_CYC;
						end
					end
				end
				`PFB_REG_ADDR:
					if (st.fsm == pfb_pkg::ST_IDLE)
					begin
						w = merge({5'h00, st.addr}, avs_writedata_in,
							avs_byteenable_in);
						next_st.addr = w[26:0];
					end
				`PFB_REG_DATA:
				begin
					w = merge({16'h0000, st.wdata}, avs_writedata_in,
						avs_byteenable_in);
					next_st.wdata = w[15:0];
					if (st.fsm != pfb_pkg::ST_IDLE && st.op == pfb_pkg::OP_BUF)
						next_st.full = 1'b1;
				end
				`PFB_REG_COUNT:
					if (st.fsm == pfb_pkg::ST_IDLE)
						next_st.count = avs_writedata_in[7:0];
				default:
					next_st.count = st.count;
			endcase
		end

		// Pin sequencer.
		unique case (st.fsm)
			pfb_pkg::ST_IDLE:
				next_st.ce_n = 1'b1;
			pfb_pkg::ST_STEP:
			begin
				next_st.last = it_last;
				next_st.pa = st.byte_mode ? it_a[26:1] : it_a[25:0];
				next_st.pd = st.byte_mode ? {it_a[0], 7'h00, it_d[7:0]} : it_d;
				next_st.pd_oe = st.byte_mode ? 16'h8000 : 16'h0000;
				if (st.op == pfb_pkg::OP_READ)
				begin
					next_st.ce_n = 1'b0;
					next_st.oe_n = 1'b0;
					// One extra cycle: the last synchroniser stage lags by one.
					next_st.cnt = ACCESS_CYC + `PFB_SYNC_CYC + 16'h0001;
					next_st.fsm = pfb_pkg::ST_READ;
				end
				else if (!it_load || st.full)
				begin
					if (it_load)
						next_st.full = 1'b0;
					next_st.ce_n = 1'b0;
					next_st.oe_n = 1'b1;
					next_st.pd_oe = st.byte_mode ? 16'h80ff : 16'hffff;
					next_st.fsm = pfb_pkg::ST_SETUP;
				end
			end
			pfb_pkg::ST_SETUP:
			begin
				next_st.we_n = 1'b0;
				next_st.cnt = WP_CYC;
				next_st.fsm = pfb_pkg::ST_PULSE;
			end
			pfb_pkg::ST_PULSE:
			begin
				next_st.cnt = st.cnt - 16'h0001;
				if (st.cnt <= 16'h0001)
				begin
					next_st.we_n = 1'b1;
					next_st.fsm = pfb_pkg::ST_HOLD;
				end
			end
			pfb_pkg::ST_HOLD:
			begin
				next_st.ce_n = 1'b1;
				next_st.pd_oe = st.byte_mode ? 16'h8000 : 16'h0000;
				next_st.step = st.step + 10'h001;
				next_st.fsm = st.last ? pfb_pkg::ST_IDLE : pfb_pkg::ST_STEP;
			end
			pfb_pkg::ST_READ:
			begin
				next_st.cnt = st.cnt - 16'h0001;
				if (st.cnt <= 16'h0001)
				begin
					next_st.rdata = st.byte_mode ? {8'h00, data_sync[7:0]}
						: data_sync;
					next_st.ce_n = 1'b1;
					next_st.oe_n = 1'b1;
					next_st.fsm = pfb_pkg::ST_IDLE;
				end
			end
			pfb_pkg::ST_RST_LOW:
			begin
				next_st.rst_n = 1'b0;
				next_st.ce_n = 1'b1;
				next_st.we_n = 1'b1;
				next_st.oe_n = 1'b1;
				next_st.pd_oe = 16'h0000;
				// Count only once the pin is low, so it stays low RP cycles.
				if (!st.rst_n)
					next_st.cnt = st.cnt - 16'h0001;
				if (st.cnt <= 16'h0001 && !st.rst_n)
				begin
					next_st.rst_n = 1'b1;
					next_st.pd_oe = st.byte_mode ? 16'h8000 : 16'h0000;
					next_st.cnt = READY_CYC;
					next_st.fsm = pfb_pkg::ST_RST_WAIT;
				end
			end
			pfb_pkg::ST_RST_WAIT:
			begin
				next_st.cnt = st.cnt - 16'h0001;
				if (ready_sync && st.cnt + `PFB_SYNC_CYC < READY_CYC)
					next_st.fsm = pfb_pkg::ST_IDLE;
				else if (st.cnt <= 16'h0001)
				begin
					next_st.tmo = 1'b1;
					next_st.fsm = pfb_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// Register the whole state; the clock enable freezes it.
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			st <= '0;
			st.wreq <= 1'b1;
			st.ce_n <= 1'b1;
			st.we_n <= 1'b1;
			st.oe_n <= 1'b1;
			st.rst_n <= 1'b1;
			st.byte_n <= 1'b1;
			st.prot_n <= 1'b1;
		end
		else if (ce_in)
			st <= next_st;
	end

	// Outputs come straight from the state flip-flops.
	assign avs_readdata_out = st.rdbus;
	assign avs_waitrequest_out = st.wreq;
	assign flash_addr_out = st.pa;
	assign flash_data_out = st.pd;
	assign flash_data_oe_out = st.pd_oe;
	assign flash_ce_n_out = st.ce_n;
	assign flash_we_n_out = st.we_n;
	assign flash_oe_n_out = st.oe_n;
	assign flash_reset_n_out = st.rst_n;
	assign flash_byte_n_out = st.byte_n;
	assign protect_accel_n_out = st.prot_n;
	assign accel_request_out = st.accel;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	logic [15:0] we_low_cnt;

	// Count how long the write strobe has been low.
	always_ff @(posedge clk_in)
	begin
		if (reset_in || st.we_n)
			we_low_cnt <= 16'h0000;
		else if (ce_in)
			we_low_cnt <= we_low_cnt + 16'h0001;
	end

	write_cycle_ok_a: assert property (!flash_we_n_out |->
		!flash_ce_n_out && flash_oe_n_out) else $error("bad write cycle");
	drive_while_read_a: assert property (!flash_oe_n_out |->
		flash_data_oe_out[14:0] == 15'h0000) else $error("data clash");
	reset_quiet_a: assert property (!flash_reset_n_out |->
		flash_ce_n_out && flash_we_n_out && flash_oe_n_out &&
		flash_data_oe_out == 16'h0000) else $error("reset not quiet");
	addr_steady_a: assert property (!flash_we_n_out || $rose(flash_we_n_out)
		|-> $stable(flash_addr_out)) else $error("address moved");
	data_steady_a: assert property ($rose(flash_we_n_out) |->
		$stable(flash_data_out) ##1 $stable(flash_data_out))
		else $error("data moved at strobe rise");
	pulse_width_a: assert property ($rose(flash_we_n_out) |->
		$past(we_low_cnt) >= WP_CYC - 16'h0001)
		else $error("write pulse short");
	byte_lsb_pin_a: assert property (!flash_byte_n_out &&
		st.fsm != pfb_pkg::ST_RST_LOW |-> flash_data_oe_out[15:8] == 8'h80)
		else $error("byte mode lanes wrong");
	standby_a: assert property (st.fsm == pfb_pkg::ST_IDLE && ce_in |=>
		flash_ce_n_out) else $error("no standby when idle");
	page_kept_a: assert property (!flash_we_n_out && st.op == pfb_pkg::OP_BUF
		&& st.step > 10'h003 && !st.byte_mode |->
		flash_addr_out[25:8] == st.addr[25:8]) else $error("left page");
	ready_wait_a: assert property (st.fsm == pfb_pkg::ST_RST_WAIT |->
		st.cnt <= READY_CYC) else $error("recovery wait too long");

	read_done_c: cover property (st.fsm == pfb_pkg::ST_READ ##1
		st.fsm == pfb_pkg::ST_IDLE);
	buf_done_c: cover property (st.op == pfb_pkg::OP_BUF &&
		st.fsm == pfb_pkg::ST_HOLD && st.last);
	reset_done_c: cover property (st.fsm == pfb_pkg::ST_RST_WAIT ##1
		st.fsm == pfb_pkg::ST_IDLE);
	page_refused_c: cover property ($rose(st.err));

endmodule : pfb_host

`default_nettype wire

//--- verif/pfb_flash_model.sv
// Behavioural parallel flash as seen from the host's pins.
`timescale 1ns/10ps
`default_nettype none

module pfb_flash_model (
	input  wire logic        clk_in,
	input  wire logic [25:0] addr_in,
	input  wire logic [15:0] data_in,
	input  wire logic        ce_n_in,
	input  wire logic        we_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        reset_n_in,
	input  wire logic        byte_n_in,
	output logic      [15:0] data_out,
	output logic      [15:0] data_oe_out,
	output logic             ready_busy_out
);
	logic [25:0] wa [0:31];
	logic [15:0] wd [0:31];
	logic [25:0] lat_a;
	logic [15:0] patt;
	logic [2:0]  rcnt = 3'h4;
	int          n = 0;
	realtime     t_fall = 0.0;

	// Address is captured as the write strobe falls.
	always @(negedge we_n_in)
	begin
		t_fall = $realtime;
		lat_a = addr_in;
	end

	// Data is taken on the rising strobe; glitches and bad cycles are lost.
	always @(posedge we_n_in)
		if (!ce_n_in && oe_n_in && reset_n_in && n < 32 &&
			$realtime - t_fall >= 5.0)
		begin
			wa[n] = lat_a;
			wd[n] = data_in;
			n = n + 1;
		end

	// Busy stays low until four cycles after the reset pin releases.
	always @(posedge clk_in)
		if (!reset_n_in)
			rcnt <= 3'h4;
		else if (rcnt != 3'h0)
			rcnt <= rcnt - 3'h1;

	// Reads always return a pattern made from the address: no id, query or lockout state.
	// Drive only while selected with output enable low; else a moving pattern.
	always_comb
	begin
		patt = addr_in[15:0] ^ 16'h5a5a;
		ready_busy_out = reset_n_in && rcnt == 3'h0;
		data_oe_out = 16'h0000;
		if (!ce_n_in && !oe_n_in && reset_n_in)
			data_oe_out = byte_n_in ? 16'hffff : 16'h00ff;
		data_out = (data_oe_out & patt) | (~data_oe_out & ~patt);
	end
endmodule : pfb_flash_model
`default_nettype wire

//--- verif/pfb_host_tb.sv
// Self-checking bench for the flash host against a behavioural flash.
`timescale 1ns/10ps
`default_nettype none
`include "pfb_regs.svh"

`define CHK(got, exp) compare(32'(got), 32'(exp))

module pfb_host_tb;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [4:0]  avs_address_in = 5'h00;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic [25:0] flash_addr_out;
	logic [15:0] flash_data_out, flash_data_oe_out, mdl_d, mdl_oe, pins;
	logic        ce_n, we_n, oe_n, rst_n, byte_n, prot_n, accel, rdy;
	logic [31:0] rd;
	int          miscompares = 0;
	int          checked = 0;
	int          base = 0;
	int          rst_low = 0;

	// Wire level of the shared data pins.
	assign pins = (flash_data_oe_out & flash_data_out) |
		(~flash_data_oe_out & mdl_d);

	pfb_host dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.flash_addr_out(flash_addr_out), .flash_data_out(flash_data_out),
		.flash_data_oe_out(flash_data_oe_out), .flash_data_in(pins),
		.flash_ce_n_out(ce_n), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n),
		.flash_reset_n_out(rst_n), .flash_byte_n_out(byte_n),
		.protect_accel_n_out(prot_n), .accel_request_out(accel),
		.ready_busy_in(rdy));

	pfb_flash_model mdl (.clk_in(clk_in), .addr_in(flash_addr_out),
		.data_in(pins), .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n),
		.reset_n_in(rst_n), .byte_n_in(byte_n), .data_out(mdl_d),
		.data_oe_out(mdl_oe), .ready_busy_out(rdy));

	// Clock of 100 ns, reset-low cycle count and a check for bus contention.
	always #50 clk_in = ~clk_in;
	always @(posedge clk_in)
	begin
		if (rst_n === 1'b0)
			rst_low++;
		if (!reset_in)
			`CHK(mdl_oe & flash_data_oe_out, 16'h0000);
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : compare

	// One Avalon access held until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [2:0] r,
		input logic [31:0] wd);
		@(posedge clk_in);
		avs_address_in <= {r, 2'b00};
		avs_writedata_in <= wd;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do
			@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0);
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask : bus

	task automatic poll(input int b, input logic v);
		do
			bus(1'b0, `PFB_REG_STAT, 32'h0);
		while (rd[b] !== v);
	endtask : poll

	task automatic run(input logic [6:0] ctrl);
		base = mdl.n;
		bus(1'b1, `PFB_REG_CTRL, {25'h0, ctrl});
		poll(`PFB_STAT_BUSY, 1'b0);
	endtask : run

	task automatic wr_chk(input int i, input logic [25:0] a,
		input logic [15:0] d);
		`CHK(mdl.wa[base + i], a);
		`CHK(mdl.wd[base + i], d);
	endtask : wr_chk

	task automatic print_verdict();
		$display("Compared %0d values, %0d mismatches", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_prog();
		`CHK(ce_n, 1'b1);
		base = mdl.n;
		bus(1'b1, 3'h6, 32'h00a0);
		bus(1'b0, 3'h6, 32'h0);
		`CHK(rd, 32'h0);
		`CHK(mdl.n - base, 0);
		bus(1'b1, `PFB_REG_ADDR, 32'h123);
		bus(1'b1, `PFB_REG_DATA, 32'hbeef);
		run(7'h03);
		`CHK(mdl.n - base, 4);
		wr_chk(0, 26'h555, 16'haa);
		wr_chk(1, 26'h2aa, 16'h55);
		wr_chk(2, 26'h555, 16'ha0);
		wr_chk(3, 26'h123, 16'hbeef);
		run(7'h43);
		`CHK(accel, 1'b1);
		`CHK(mdl.n - base, 2);
		wr_chk(1, 26'h123, 16'hbeef);
	endtask : t_prog

	task automatic t_read();
		bus(1'b1, `PFB_REG_ADDR, 32'h456);
		run(7'h21);
		`CHK(prot_n, 1'b0);
		bus(1'b0, `PFB_REG_RDATA, 32'h0);
		`CHK(rd, 32'h5e0c);
		bus(1'b1, `PFB_REG_ADDR, 32'h457);
		run(7'h11);
		`CHK(byte_n, 1'b0);
		bus(1'b0, `PFB_REG_RDATA, 32'h0);
		`CHK(rd, 32'h71);
	endtask : t_read

	task automatic t_buf();
		bus(1'b1, `PFB_REG_ADDR, 32'h10);
		bus(1'b1, `PFB_REG_COUNT, 32'h1);
		base = mdl.n;
		bus(1'b1, `PFB_REG_CTRL, 32'h05);
		poll(`PFB_STAT_NEED, 1'b1);
		bus(1'b1, `PFB_REG_DATA, 32'h1111);
		bus(1'b1, `PFB_REG_DATA, 32'h2222);
		poll(`PFB_STAT_BUSY, 1'b0);
		`CHK(mdl.n - base, 7);
		wr_chk(2, 26'h10, 16'h25);
		wr_chk(3, 26'h10, 16'h01);
		wr_chk(4, 26'h10, 16'h1111);
		wr_chk(5, 26'h11, 16'h2222);
		wr_chk(6, 26'h10, 16'h29);
		bus(1'b1, `PFB_REG_ADDR, 32'hf0);
		bus(1'b1, `PFB_REG_COUNT, 32'h1f);
		run(7'h05);
		`CHK(rd[`PFB_STAT_ERR], 1'b1);
		`CHK(mdl.n - base, 0);
	endtask : t_buf

	task automatic t_reset_ops();
		run(7'h07);
		`CHK(mdl.n - base, 3);
		wr_chk(2, 26'h555, 16'hf0);
		run(7'h09);
		wr_chk(0, 26'hf0, 16'hf0);
		run(7'h0b);
		`CHK(rd[`PFB_STAT_TMO], 1'b0);
		`CHK(rd[`PFB_STAT_READY], 1'b1);
		`CHK(rst_low >= `PFB_RP_CYC, 1'b1);
		`CHK(mdl.n - base, 0);
		`CHK(ce_n, 1'b1);
	endtask : t_reset_ops

	// Main sequence after a reset of twelve cycles.
	initial
	begin
		repeat (12) @(posedge clk_in);
		reset_in <= 1'b0;
		t_prog();
		t_read();
		t_buf();
		t_reset_ops();
		print_verdict();
	end

	// Watchdog well past the expected run of a few hundred cycles.
	initial
	begin
		#3000000;
		miscompares++;
		print_verdict();
	end
endmodule : pfb_host_tb
`default_nettype wire
